// ### cml_consts.svh
// constants for the cell model lookup block
// assumes a single 25 MHz clock and whole-degree temperature input
`ifndef CML_CONSTS_SVH
`define CML_CONSTS_SVH
`define CML_CLK_KHZ 25000
`define CML_TICK_MS 440
`define CML_TOP_DEG 9'sd40
`define CML_SEG1_DEG 9'sd10
`define CML_SEG2_DEG 9'sd20
`define CML_SEG3_DEG 9'sd30
`define CML_UNITY 16'h4000
`define CML_AE_SHIFT 4'h4
`define CML_AGE_SHIFT 5'h5
`define CML_WEAR_UNAGED 8'h80
`define CML_WEAR_MIN 8'h3F
`define CML_C_FULL 0
`define CML_C_AE 1
`define CML_C_SE 2
`define CML_IDX_SENSE 3'h0
`define CML_IDX_CHG_V 3'h1
`define CML_IDX_TERM_I 3'h2
`define CML_IDX_AE_V 3'h3
`define CML_IDX_AE_I 3'h4
`define CML_IDX_WREF_HI 3'h5
`define CML_IDX_WREF_LO 3'h6
`define CML_IDX_WEAR 3'h7
`define CML_PARAM_RST 8'h00
`endif

// ### cml_pkg.sv
// types shared by the cell model lookup block
// assumes nothing beyond the constants header
`default_nettype none
package cml_pkg;
  typedef struct packed {
    logic [15:0] full;
    logic [15:0] active_empty;
    logic [15:0] standby_empty;
  } cml_curve_s;
  typedef struct packed {
    logic [15:0] full40;
    logic [7:0] ae40;
    logic [2:0][3:0][7:0] slope;
  } cml_model_s;
  typedef struct packed {
    logic [7:0] sense_conductance;
    logic [7:0] charge_voltage_threshold;
    logic [7:0] termination_current_threshold;
    logic [7:0] active_empty_voltage;
    logic [7:0] active_empty_current;
    logic [15:0] wear_reference;
  } cml_app_s;
  typedef enum logic {CML_IDLE, CML_WALK} cml_state_e;
endpackage
`default_nettype wire

// ### cml_lookup.sv
// cell model lookup: rebuilds full and empty curves, holds parameters
// assumes model data and temperature come from logic on the same clock
//
// Behaviour
// - three curves, full, active and standby empty, four segments each
// - above forty degrees each curve holds its forty degree value
// - below zero each curve extends with its first segment slope
// - curves rebuilt in whole degree steps only
// - points normalised to forty degree full, stored in 6.25uVh units
// - active empty at forty stored as fraction, resolution 2^-10
// - standby empty at forty is fixed zero, not stored
// - slopes per degree, segment ends at 0,10,20,30,40 degrees
// - sense conductance is one byte of reciprocal shunt resistance
// - charge voltage threshold one byte, 19.52 mV per count
// - termination current threshold one byte, 50 uV units
// - active empty voltage one byte, 19.52 mV per count
// - active empty current unsigned byte, 200 uV units
// - wear reference two bytes in charge count units
// - wear factor one byte, 80h is unaged, floor near 49.2 percent
// - wear factor updated by aging and learning, scales capacity
// - host may read and write the wear factor at any time
// - wear factor saved to nonvolatile store, recalled at power-up
// - no standby current or voltage parameters are held
// - after 32 times wear reference of discharge, wear factor drops
// - lookup re-run every 440 ms
`default_nettype none
`include "cml_consts.svh"
module cml_lookup #(
  parameter int P_TICK_CYC = `CML_TICK_MS * `CML_CLK_KHZ
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic signed [7:0] i_temp,
  input wire cml_pkg::cml_model_s i_model,
  input wire logic i_reg_we,
  input wire logic [2:0] i_reg_idx,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_recall_valid,
  input wire logic [7:0] i_recall_wear,
  input wire logic i_learn_valid,
  input wire logic [7:0] i_learn_wear,
  input wire logic i_discharge_step,
  output logic o_nv_save,
  output logic [7:0] o_nv_wear,
  output cml_pkg::cml_app_s o_app,
  output logic [7:0] o_wear_factor,
  output cml_pkg::cml_curve_s o_curves,
  output logic [15:0] o_full_aged,
  output logic o_valid
);
  import cml_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [1:0] seg_of(input logic signed [8:0] p);
    if (p > `CML_SEG3_DEG) begin
      return 2'h3;
    end else if (p > `CML_SEG2_DEG) begin
      return 2'h2;
    end else if (p > `CML_SEG1_DEG) begin
      return 2'h1;
    end
    return 2'h0;
  endfunction

  // ==========================================================
  // 440 ms processing tick
  logic [23:0] tick_cnt;
  logic tick;
  assign tick = (tick_cnt == 24'(P_TICK_CYC - 1));
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tick_cnt <= 24'h00_0000;
    end else if (tick) begin
      tick_cnt <= 24'h00_0000;
    end else begin
      tick_cnt <= tick_cnt + 24'h00_0001;
    end
  end

  // ==========================================================
  // application parameters
  cml_app_s app;
  logic [7:0] wear_factor;
  assign o_app = app;
  assign o_wear_factor = wear_factor;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      app <= '0;
    end else if (i_reg_we) begin
      if (i_reg_idx == `CML_IDX_SENSE) begin
        app.sense_conductance <= i_reg_wdata;
      end else if (i_reg_idx == `CML_IDX_CHG_V) begin
        app.charge_voltage_threshold <= i_reg_wdata;
      end else if (i_reg_idx == `CML_IDX_TERM_I) begin
        app.termination_current_threshold <= i_reg_wdata;
      end else if (i_reg_idx == `CML_IDX_AE_V) begin
        app.active_empty_voltage <= i_reg_wdata;
      end else if (i_reg_idx == `CML_IDX_AE_I) begin
        app.active_empty_current <= i_reg_wdata;
      end else if (i_reg_idx == `CML_IDX_WREF_HI) begin
        app.wear_reference[15:8] <= i_reg_wdata;
      end else if (i_reg_idx == `CML_IDX_WREF_LO) begin
        app.wear_reference[7:0] <= i_reg_wdata;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= `CML_PARAM_RST;
    end else if (i_reg_idx == `CML_IDX_SENSE) begin
      o_reg_rdata <= app.sense_conductance;
    end else if (i_reg_idx == `CML_IDX_CHG_V) begin
      o_reg_rdata <= app.charge_voltage_threshold;
    end else if (i_reg_idx == `CML_IDX_TERM_I) begin
      o_reg_rdata <= app.termination_current_threshold;
    end else if (i_reg_idx == `CML_IDX_AE_V) begin
      o_reg_rdata <= app.active_empty_voltage;
    end else if (i_reg_idx == `CML_IDX_AE_I) begin
      o_reg_rdata <= app.active_empty_current;
    end else if (i_reg_idx == `CML_IDX_WREF_HI) begin
      o_reg_rdata <= app.wear_reference[15:8];
    end else if (i_reg_idx == `CML_IDX_WREF_LO) begin
      o_reg_rdata <= app.wear_reference[7:0];
    end else begin
      o_reg_rdata <= wear_factor;
    end
  end

  // ==========================================================
  // aging estimation
  logic [20:0] age_cnt;
  logic age_hit;
  logic host_wear;
  assign host_wear = i_reg_we && (i_reg_idx == `CML_IDX_WEAR);
  assign age_hit = i_discharge_step && (app.wear_reference != 16'h0000)
    && ((age_cnt + 21'h00_0001) >= {app.wear_reference, 5'h00});
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      age_cnt <= 21'h00_0000;
    end else if (age_hit) begin
      age_cnt <= 21'h00_0000;
    end else if (i_discharge_step) begin
      age_cnt <= age_cnt + 21'h00_0001;
    end
  end

  // host write first, then recall, learn, aging
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wear_factor <= `CML_WEAR_UNAGED;
    end else if (host_wear) begin
      wear_factor <= i_reg_wdata;
    end else if (i_recall_valid) begin
      wear_factor <= i_recall_wear;
    end else if (i_learn_valid) begin
      wear_factor <= i_learn_wear;
    end else if (age_hit && wear_factor > `CML_WEAR_MIN) begin
      wear_factor <= wear_factor - 8'h01;
    end
  end

  // ==========================================================
  // nonvolatile save on each tick after a change
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_nv_save <= 1'b0;
      o_nv_wear <= `CML_WEAR_UNAGED;
    end else begin
      o_nv_save <= tick && (wear_factor != o_nv_wear);
      if (i_recall_valid) begin
        o_nv_wear <= i_recall_wear;
      end else if (tick) begin
        o_nv_wear <= wear_factor;
      end
    end
  end

  // ==========================================================
  // curve walk, one degree per cycle
  cml_state_e state;
  logic signed [8:0] pos;
  logic signed [8:0] tgt;
  logic hot;
  logic walk_done;
  logic [1:0] seg;
  logic [15:0] val [3];
  assign walk_done = (state == CML_WALK) && (pos == tgt);
  assign seg = seg_of(pos);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= CML_IDLE;
      pos <= `CML_TOP_DEG;
      tgt <= `CML_TOP_DEG;
      hot <= 1'b0;
    end else begin
      case (state)
        CML_IDLE: begin
          if (tick) begin
            state <= CML_WALK;
            pos <= `CML_TOP_DEG;
            hot <= ($signed(i_temp) >= `CML_TOP_DEG);
            if ($signed(i_temp) > `CML_TOP_DEG) begin
              tgt <= `CML_TOP_DEG;
            end else begin
              tgt <= 9'(i_temp);
            end
          end
        end
        default: begin
          if (pos == tgt) begin
            state <= CML_IDLE;
          end else begin
            pos <= pos - 9'sd1;
          end
        end
      endcase
    end
  end

  for (genvar c = 0; c < 3; c++) begin : g_curve
    logic [15:0] slp;
    logic [15:0] start;
    logic [16:0] sum;
    assign slp = {8'h00, i_model.slope[c][seg]};
    if (c == `CML_C_FULL) begin : g_full
      assign start = `CML_UNITY;
    end else if (c == `CML_C_AE) begin : g_ae
      assign start = {4'h0, i_model.ae40, 4'h0};
    end else begin : g_se
      assign start = 16'h0000;
    end
    if (c == `CML_C_FULL) begin : g_sub
      assign sum = {1'b0, val[c]} - {1'b0, slp};
    end else begin : g_add
      assign sum = {1'b0, val[c]} + {1'b0, slp};
    end
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        val[c] <= 16'h0000;
      end else if (state == CML_IDLE && tick) begin
        val[c] <= start;
      end else if (state == CML_WALK && pos != tgt) begin
        if (sum[16]) begin
          val[c] <= (c == `CML_C_FULL) ? 16'h0000 : 16'hFFFF;
        end else begin
          val[c] <= sum[15:0];
        end
      end
    end
  end

  // ==========================================================
  // results
  logic [31:0] abs_prod;
  logic [23:0] aged_prod;
  assign abs_prod = i_model.full40 * val[`CML_C_FULL];
  assign aged_prod = abs_prod[29:14] * wear_factor;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_curves <= '0;
      o_full_aged <= 16'h0000;
      o_valid <= 1'b0;
    end else begin
      o_valid <= walk_done;
      if (walk_done) begin
        o_curves.full <= val[`CML_C_FULL];
        o_curves.active_empty <= val[`CML_C_AE];
        o_curves.standby_empty <= val[`CML_C_SE];
        o_full_aged <= aged_prod[22:7];
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  tick_start_a: assert property (tick && state == CML_IDLE |=>
    state == CML_WALK && pos == `CML_TOP_DEG)
    else $error("lookup did not start on tick");
  walk_done_a: assert property (walk_done |=> o_valid &&
    o_curves.full == $past(val[`CML_C_FULL]))
    else $error("lookup result not published");
  one_degree_a: assert property (state == CML_WALK && pos != tgt |=>
    pos == $past(pos) - 9'sd1)
    else $error("walk step not one degree");
  hot_hold_a: assert property (o_valid && hot |->
    o_curves.full == `CML_UNITY && o_curves.standby_empty == 16'h0000)
    else $error("hot curve not held at forty degree value");
  se_zero_a: assert property (tick && state == CML_IDLE |=>
    val[`CML_C_SE] == 16'h0000)
    else $error("standby empty start not zero");
  cold_ext_a: assert property (state == CML_WALK && pos != tgt
    && pos <= 9'sd0 && val[`CML_C_AE] < 16'hFE00 |=>
    val[`CML_C_AE] == $past(val[`CML_C_AE])
    + {8'h00, $past(i_model.slope[`CML_C_AE][0])})
    else $error("cold extension not using first slope");
  age_dec_a: assert property (age_hit && !host_wear && !i_recall_valid
    && !i_learn_valid && wear_factor > `CML_WEAR_MIN |=>
    wear_factor == $past(wear_factor) - 8'h01 && age_cnt == 21'h00_0000)
    else $error("aging decrement missed");
  host_wear_a: assert property (host_wear |=>
    wear_factor == $past(i_reg_wdata))
    else $error("host wear write lost");
  nv_save_a: assert property (tick && wear_factor != o_nv_wear |=>
    o_nv_save && o_nv_wear == $past(wear_factor))
    else $error("wear factor not saved");

  cold_walk_c: cover property (o_valid && o_curves.active_empty != 16'h0000
    && tgt < 9'sd0);
  age_dec_c: cover property (age_hit && wear_factor > `CML_WEAR_MIN);
  nv_save_c: cover property (o_nv_save);
endmodule
`default_nettype wire

// ### cml_lookup_tb.sv
// self-checking bench for the cell model lookup block
// assumes cml_pkg and cml_lookup are compiled first; tick cut to 200 cycles
`default_nettype none
module cml_lookup_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cml_pkg::*;
  localparam int TICK = 200;
  typedef struct packed {
    cml_curve_s c;
    logic [15:0] a;
  } cml_res_s;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic signed [7:0] temp = 8'sd25;
  cml_model_s model = '0;
  logic we = 1'b0, rec = 1'b0, lrn = 1'b0, dis = 1'b0, rd_look = 1'b0;
  logic [2:0] idx = 3'h0;
  logic [7:0] wd = 8'h00, lv = 8'h00, wexp = 8'h80;
  logic [7:0] rdata, nv_wear, wear;
  logic nv_save, valid;
  logic [7:0] regv[7];
  cml_app_s app;
  cml_curve_s curves;
  logic [15:0] aged;
  int failures = 0, tests_run = 0, nvalid = 0, seed = 48;
  logic [7:0] rq[$];
  logic [7:0] sq[$];
  cml_res_s lq[$];

  always #20 i_clk = ~i_clk;

  cml_lookup #(.P_TICK_CYC(TICK)) DUT (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_temp(temp), .i_model(model),
    .i_reg_we(we), .i_reg_idx(idx), .i_reg_wdata(wd), .o_reg_rdata(rdata),
    .i_recall_valid(rec), .i_recall_wear(lv), .i_learn_valid(lrn),
    .i_learn_wear(lv), .i_discharge_step(dis), .o_nv_save(nv_save),
    .o_nv_wear(nv_wear), .o_app(app), .o_wear_factor(wear),
    .o_curves(curves), .o_full_aged(aged), .o_valid(valid)
  );

  // ==========================================================
  // reporting
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // drivers; m is {host write, learn, recall}
  task automatic evt(input logic [2:0] m, input logic [2:0] ix,
                     input logic [7:0] hv, input logic [7:0] v);
    @(posedge i_clk);
    #1 {we, lrn, rec} = m;
    idx = ix;
    wd = hv;
    lv = v;
    @(posedge i_clk);
    #1 {we, lrn, rec} = 3'b000;
  endtask

  task automatic rd(input logic [2:0] ix, input logic [7:0] e);
    @(posedge i_clk);
    #1 idx = ix;
    @(posedge i_clk);
    #1 rq.push_back(e);
    rd_look = 1'b1;
    @(posedge i_clk);
    #1 rd_look = 1'b0;
  endtask

  task automatic step(input int n);
    repeat (n) begin
      @(posedge i_clk);
      #1 dis = 1'b1;
      @(posedge i_clk);
      #1 dis = 1'b0;
    end
  endtask

  task automatic rand_model();
    model.full40 = 16'($random(seed));
    model.ae40 = 8'($random(seed));
    for (int c = 0; c < 3; c++) begin
      for (int s = 0; s < 4; s++) begin
        model.slope[c][s] = 8'($random(seed));
      end
    end
  endtask

  // walk from forty degrees down to temp, one degree per step
  task automatic push_lk();
    int f, ae, se, s;
    longint t;
    cml_res_s r;
    f = 16384;
    ae = int'(model.ae40) << 4;
    se = 0;
    for (int p = 40; p > temp; p--) begin
      s = (p > 30) ? 3 : (p > 20) ? 2 : (p > 10) ? 1 : 0;
      f = f - model.slope[0][s];
      if (f < 0) f = 0;
      ae = ae + model.slope[1][s];
      if (ae > 65535) ae = 65535;
      se = se + model.slope[2][s];
      if (se > 65535) se = 65535;
    end
    t = ((longint'(model.full40) * f) >> 14) * wexp;
    r.c.full = f[15:0];
    r.c.active_empty = ae[15:0];
    r.c.standby_empty = se[15:0];
    r.a = t[22:7];
    lq.push_back(r);
  endtask

  task automatic wait_valid();
    int n;
    n = nvalid;
    for (int k = 0; k < 2 * TICK && nvalid == n; k++) begin
      @(posedge i_clk);
      #1;
    end
    if (nvalid == n) begin
      failures++;
      wrap_up();
    end
  endtask

  // ==========================================================
  // result monitor
  always @(negedge i_clk) begin
    if (rd_look) check(16'(rdata), 16'(rq.pop_front()));
    if (valid === 1'b1) begin
      nvalid++;
      check(16'(lq.size() > 0), 16'h0001);
      if (lq.size() > 0) begin
        check(curves.full, lq[0].c.full);
        check(curves.active_empty, lq[0].c.active_empty);
        check(curves.standby_empty, lq[0].c.standby_empty);
        check(aged, lq[0].a);
        void'(lq.pop_front());
      end
    end
    if (nv_save === 1'b1) begin
      check(16'(sq.size()), 16'h0001);
      if (sq.size() > 0) check(16'(nv_wear), 16'(sq.pop_front()));
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    rand_model();
    repeat (8) @(posedge i_clk);
    #1 i_nrst = 1'b1;
    check(16'(wear), 16'h0080);
    // pack starts near 95 percent, saved at the first tick
    wexp = 8'h7a;
    evt(3'b100, 3'h7, wexp, 8'h00);
    sq.push_back(wexp);
    push_lk();
    wait_valid();
    for (int i = 0; i < 7; i++) begin
      regv[i] = 8'($random(seed));
      evt(3'b100, 3'(i), regv[i], 8'h00);
      rd(3'(i), regv[i]);
    end
    check(16'(app.sense_conductance), 16'(regv[0]));
    check(16'(app.charge_voltage_threshold), 16'(regv[1]));
    check(16'(app.termination_current_threshold), 16'(regv[2]));
    check(16'(app.active_empty_voltage), 16'(regv[3]));
    check(16'(app.active_empty_current), 16'(regv[4]));
    check(app.wear_reference, {regv[5], regv[6]});
    // kept below 7ah so that a save always follows
    wexp = 8'h40 + 8'($random(seed) & 32'h1f);
    evt(3'b100, 3'h7, wexp, 8'h00);
    rd(3'h7, wexp);
    sq.push_back(wexp);
    temp = 8'sd45;
    push_lk();
    wait_valid();
    evt(3'b100, 3'h5, 8'h00, 8'h00);
    evt(3'b100, 3'h6, 8'h01, 8'h00);
    evt(3'b100, 3'h7, 8'h40, 8'h00);
    step(31);
    rd(3'h7, 8'h40);
    step(1);
    rd(3'h7, 8'h3f);
    wexp = 8'h3f;
    sq.push_back(wexp);
    temp = 8'sd0;
    push_lk();
    wait_valid();
    step(32);
    rd(3'h7, 8'h3f);
    evt(3'b010, 3'h7, 8'h00, 8'h70);
    rd(3'h7, 8'h70);
    evt(3'b110, 3'h7, 8'h55, 8'h66);
    rd(3'h7, 8'h55);
    evt(3'b001, 3'h7, 8'h00, 8'h60);
    rd(3'h7, 8'h60);
    check(16'(nv_wear), 16'h0060);
    wexp = 8'h60;
    temp = -8'sd3;
    push_lk();
    wait_valid();
    rand_model();
    temp = 8'sd38;
    push_lk();
    wait_valid();
    check(16'(sq.size()), 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
